// >>> core/sdram_write_map_consts.vh
/*
 * Shared constants for the SDRAM write path, address map and async port.
 * Assumes inclusion by bare name from the design files under core/.
 */
`ifndef SDRAM_WRITE_MAP_CONSTS_VH
`define SDRAM_WRITE_MAP_CONSTS_VH

// {ras_n, cas_n, we_n} with chip select low
`define CMD_NOP       3'h7
`define CMD_ACT       3'h3
`define CMD_WRT       3'h4
`define CMD_PRE       3'h2
`define CMD_BT        3'h6

`define NM_WIDE       1'h0
`define NM_NARROW     1'h1
`define BL_WIDE       4'h4
`define BL_NARROW     4'h8
`define STEP_WIDE     32'h4
`define STEP_NARROW   32'h2
`define SHIFT_WIDE    5'h2
`define SHIFT_NARROW  5'h1
`define COL_MIN_BITS  5'h8
`define AP_BIT        10
`define ALL_MASKED    4'hF
`define NO_MASK       4'h0

`define SS_WE_STROBE  1'h0
`define ECC_MAX_BYTES 10'h200

`endif

// >>> core/nand_ecc_acc.v
/*
 * Flash-mode error correction accumulator: 18 line parity bits and
 * 6 column parity bits over up to 512 bytes, cleared by software strobe.
 * Assumes one byte per byte_valid pulse, same clock as the caller.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sdram_write_map_consts.vh"

module nand_ecc_acc (
  input  wire        clock,
  input  wire        reset,
  input  wire        clear,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  output reg  [23:0] ecc_value
);
  reg  [9:0]  count_reg;
  reg  [23:0] ecc_next;
  reg         par;
  integer     k;

  always @* begin
    ecc_next = ecc_value;
    par = ^byte_data;
    for (k = 0; k < 9; k = k + 1) begin
      if (count_reg[k])
        ecc_next[2*k+1] = ecc_value[2*k+1] ^ par;
      else
        ecc_next[2*k] = ecc_value[2*k] ^ par;
    end
    for (k = 0; k < 3; k = k + 1) begin
      ecc_next[18+2*k] = ecc_value[18+2*k] ^ byte_data[0] ^ byte_data[1+k];
      ecc_next[19+2*k] = ecc_value[19+2*k] ^ byte_data[7] ^ byte_data[6-k];
    end
  end

  always @(posedge clock) begin
    if (reset || clear) begin
      count_reg <= 10'h000;
      ecc_value <= 24'h000000;
    end else if (byte_valid && count_reg < `ECC_MAX_BYTES) begin
      count_reg <= count_reg + 10'h001;
      ecc_value <= ecc_next;
    end
  end
endmodule // nand_ecc_acc

`default_nettype wire

// >>> core/sdram_write_map_async_modes.v
/*
 * SDRAM write engine with logical-to-pin address mapping, and the async
 * port strobe modes, flash ECC and extended wait. Shares the memory pins.
 * Assumes a requester that presents words on wd_* and external devices
 * on the memory pins; async_wait comes from outside the clock domain.
 */
// Functional notes
// - each write cycle: activate bank and row, then write with bank and column
// - address bit 10 low during write so no auto precharge
// - first data with write command, next words with burst nops
// - burst four on 32-bit bus, eight on 16-bit bus
// - cut burst: new write same page, precharge same bank, stop other bank
// - byte masks pick bytes, whole unwanted burst words masked
// - timing parameters respected by inserting nops
// - row, column, bank taken from address by bank count, page size, width
// - column steps per word; page crossing moves to next bank, column zero
// - page left open in previous bank until needed closed
// - any number of open banks, one open row per bank
// - byte masks low whenever an activate, precharge or burst stop goes out
// - 32-bit: address 1:0 select bytes, column from bit 2
// - 16-bit: address 0 selects byte, column from bit 1
// - write-strobe mode: masks are write strobes, select held all access
// - select-strobe mode: select only in strobe, masks are byte enables
// - reset gives write-strobe mode; config bit selects select-strobe
// - write-strobe mode lets 8-bit devices share one select
// - flash sub-mode computes ECC over up to 512 bytes
// - programmable async timing; extended wait lengthens strobe
`timescale 1ns/10ps
`default_nettype none
`include "sdram_write_map_consts.vh"

module sdram_write_map_async_modes #(
  parameter DW = 32,
  parameter LW = 8
) (
  input  wire          clock,
  input  wire          reset,
  input  wire          narrow_bus_select,
  input  wire [1:0]    bank_count_field,
  input  wire [1:0]    page_size_field,
  input  wire [3:0]    t_rcd,
  input  wire [3:0]    t_rp,
  input  wire [3:0]    t_wr,
  input  wire          wr_req,
  input  wire [31:0]   wr_addr,
  input  wire [LW-1:0] wr_len,
  output wire          wr_req_ready,
  output reg           wr_done,
  input  wire          wd_valid,
  input  wire [DW-1:0] wd_data,
  input  wire [3:0]    wd_be,
  output wire          wd_ready,
  input  wire          strobe_mode_select,
  input  wire          nand_mode,
  input  wire          ext_wait_enable,
  input  wire [3:0]    a_setup,
  input  wire [3:0]    a_strobe,
  input  wire [3:0]    a_hold,
  input  wire          async_req,
  input  wire          async_write,
  input  wire [31:0]   async_addr,
  input  wire [3:0]    async_be,
  input  wire [DW-1:0] async_wdata,
  output wire          async_req_ready,
  output reg           async_done,
  output reg  [DW-1:0] async_rdata,
  input  wire          ecc_clear,
  output wire [23:0]   ecc_value,
  input  wire          async_wait,
  output reg           sd_cs_n,
  output reg           sd_ras_n,
  output reg           sd_cas_n,
  output reg           sd_we_n,
  output reg  [12:0]   mem_addr_pins,
  output reg  [1:0]    mem_bank_addr_pins,
  output reg  [3:0]    byte_mask_strobe_pins,
  output reg  [DW-1:0] mem_data_out,
  output reg           mem_data_oe_n,
  input  wire [DW-1:0] mem_data_in,
  output reg           async_chip_select_n,
  output reg           async_oe_n,
  output reg           async_we_n
);
  localparam S_IDLE = 4'h1, S_RUN = 4'h2, S_WAIT = 4'h4, S_DONE = 4'h8;
  localparam A_IDLE = 4'h1, A_SETUP = 4'h2, A_STROBE = 4'h4, A_HOLD = 4'h8;

  // returns {bank[1:0], row[12:0], col[10:0]}
  function [25:0] map_addr;
    input [31:0] a;
    input        nm;
    input [1:0]  ib;
    input [1:0]  ps;
    reg   [31:0] w;
    reg   [4:0]  cb;
    reg   [10:0] col;
    reg   [1:0]  bk;
    begin
      w = a >> ((nm == `NM_NARROW) ? `SHIFT_NARROW : `SHIFT_WIDE);
      cb = `COL_MIN_BITS + {3'h0, ps};
      col = w[10:0] & ((11'h001 << cb) - 11'h001);
      w = w >> cb;
      bk = (ib == 2'h0) ? 2'h0 : (ib == 2'h1) ? {1'b0, w[0]} : w[1:0];
      w = w >> ib;
      map_addr = {bk, w[12:0], col};
    end
  endfunction

  function [3:0] lane_mask;
    input       nm;
    input [1:0] lo;
    begin
      if (nm == `NM_NARROW)
        lane_mask = (4'h3 << lo[0]) & 4'h3;
      else
        lane_mask = 4'hF << lo;
    end
  endfunction

  reg [3:0]    st_reg, st_next;
  reg [31:0]   cur_reg, cur_next;
  reg [LW-1:0] left_reg, left_next;
  reg [3:0]    blen_reg, blen_next;
  reg [1:0]    bb_reg, bb_next;
  reg [10:0]   ncol_reg, ncol_next;
  reg [3:0]    wait_reg, wait_next;
  reg [3:0]    rec_reg, rec_next;
  reg [3:0]    open_reg, open_next;
  reg [12:0]   row_reg [0:3];
  reg          act_set, pre_clr;
  reg          take;
  reg          done_next;
  reg [2:0]    cmd;
  reg [12:0]   a_pins;
  reg [3:0]    dqm;

  wire [25:0] m      = map_addr(cur_reg, narrow_bus_select, bank_count_field,
                                page_size_field);
  wire [1:0]  m_bank = m[25:24];
  wire [12:0] m_row  = m[23:11];
  wire [10:0] m_col  = m[10:0];
  wire [3:0]  bl     = (narrow_bus_select == `NM_NARROW) ? `BL_NARROW
                                                         : `BL_WIDE;
  wire [31:0] step   = (narrow_bus_select == `NM_NARROW) ? `STEP_NARROW
                                                         : `STEP_WIDE;
  wire        row_hit = open_reg[m_bank] && (row_reg[m_bank] == m_row);
  wire        cont_ok = (blen_reg != 4'h0) && (m_bank == bb_reg) &&
                        (m_col == ncol_reg) &&
                        ((m_col[3:0] & (bl - 4'h1)) != 4'h0) && wd_valid;

  reg [3:0]    ast_reg;
  reg [3:0]    acnt_reg;
  reg          a_wr_reg;
  reg [31:0]   a_addr_reg;
  reg [3:0]    a_be_reg;
  reg [DW-1:0] a_wdata_reg;
  reg          ss_mode_reg;
  reg          w_s1, w_s2, w_s3, wait_reg_sync;

  assign wr_req_ready    = (st_reg == S_IDLE) && (ast_reg == A_IDLE);
  assign async_req_ready = (st_reg == S_IDLE) && (ast_reg == A_IDLE) && !wr_req;
  assign wd_ready        = take;

  always @* begin
    st_next   = st_reg;
    cur_next  = cur_reg;
    left_next = left_reg;
    blen_next = (blen_reg != 4'h0) ? blen_reg - 4'h1 : 4'h0;
    bb_next   = bb_reg;
    ncol_next = ncol_reg;
    wait_next = wait_reg;
    rec_next  = (rec_reg != 4'h0) ? rec_reg - 4'h1 : 4'h0;
    act_set   = 1'b0;
    pre_clr   = 1'b0;
    take      = 1'b0;
    done_next = 1'b0;
    cmd       = `CMD_NOP;
    a_pins    = 13'h0000;
    // unused burst slots are masked whole
    dqm = (blen_reg != 4'h0) ? `ALL_MASKED : `NO_MASK;
    case (st_reg)
      S_IDLE: begin
        if (wr_req && ast_reg == A_IDLE && wr_len != {LW{1'b0}}) begin
          cur_next  = wr_addr;
          left_next = wr_len;
          st_next   = S_RUN;
        end
      end
      S_RUN: begin
        if (left_reg == {LW{1'b0}}) begin
          if (blen_reg == 4'h0)
            st_next = S_DONE;
        end else if (cont_ok) begin
          take = 1'b1;
        end else if (row_hit) begin
          if (wd_valid) begin
            cmd       = `CMD_WRT;
            a_pins    = {1'b0, m_col[10], 1'b0, m_col[9:0]};
            take      = 1'b1;
            blen_next = bl - 4'h1;
            bb_next   = m_bank;
          end
        end else if (blen_reg != 4'h0 && m_bank != bb_reg) begin
          cmd       = `CMD_BT;
          blen_next = 4'h0;
        end else if (open_reg[m_bank]) begin
          if (rec_reg == 4'h0) begin
            cmd       = `CMD_PRE;
            a_pins    = 13'h0000;
            pre_clr   = 1'b1;
            blen_next = 4'h0;
            if (t_rp > 4'h1) begin
              wait_next = t_rp - 4'h1;
              st_next   = S_WAIT;
            end
          end
        end else begin
          cmd     = `CMD_ACT;
          a_pins  = m_row;
          act_set = 1'b1;
          if (t_rcd > 4'h1) begin
            wait_next = t_rcd - 4'h1;
            st_next   = S_WAIT;
          end
        end
        if (take) begin
          dqm       = ~(wd_be & lane_mask(narrow_bus_select, cur_reg[1:0]));
          if (narrow_bus_select == `NM_NARROW)
            dqm[3:2] = 2'h3;
          cur_next  = (cur_reg & ~(step - 32'h1)) + step;
          ncol_next = m_col + 11'h001;
          left_next = left_reg - {{(LW-1){1'b0}}, 1'b1};
          rec_next  = t_wr;
        end
        if (cmd != `CMD_NOP && cmd != `CMD_WRT)
          dqm = `NO_MASK;
      end
      S_WAIT: begin
        wait_next = wait_reg - 4'h1;
        if (wait_reg == 4'h1)
          st_next = S_RUN;
      end
      S_DONE: begin
        done_next = 1'b1;
        st_next   = S_IDLE;
      end
      default: st_next = S_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      st_reg   <= S_IDLE;
      cur_reg  <= 32'h00000000;
      left_reg <= {LW{1'b0}};
      blen_reg <= 4'h0;
      bb_reg   <= 2'h0;
      ncol_reg <= 11'h000;
      wait_reg <= 4'h0;
      rec_reg  <= 4'h0;
      open_reg <= 4'h0;
      wr_done  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cur_reg  <= cur_next;
      left_reg <= left_next;
      blen_reg <= blen_next;
      bb_reg   <= bb_next;
      ncol_reg <= ncol_next;
      wait_reg <= wait_next;
      rec_reg  <= rec_next;
      wr_done  <= done_next;
      if (act_set)
        open_reg[m_bank] <= 1'b1;
      if (pre_clr)
        open_reg[m_bank] <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (act_set)
      row_reg[m_bank] <= m_row;
  end

  // wait pin: three stages, accepted once stages two and three agree
  always @(posedge clock) begin
    if (reset) begin
      w_s1          <= 1'b0;
      w_s2          <= 1'b0;
      w_s3          <= 1'b0;
      wait_reg_sync <= 1'b0;
    end else begin
      w_s1 <= async_wait;
      w_s2 <= w_s1;
      w_s3 <= w_s2;
      if (w_s2 == w_s3)
        wait_reg_sync <= w_s3;
    end
  end

  wire strobe_end = (ast_reg == A_STROBE) && (acnt_reg == 4'h0) &&
                    !(ext_wait_enable && wait_reg_sync);

  nand_ecc_acc u_nand_ecc_acc (
    .clock      (clock),
    .reset      (reset),
    .clear      (ecc_clear),
    .byte_valid (strobe_end && nand_mode),
    .byte_data  (a_wr_reg ? a_wdata_reg[7:0] : mem_data_in[7:0]),
    .ecc_value  (ecc_value)
  );

  always @(posedge clock) begin
    if (reset) begin
      ast_reg     <= A_IDLE;
      acnt_reg    <= 4'h0;
      a_wr_reg    <= 1'b0;
      a_addr_reg  <= 32'h00000000;
      a_be_reg    <= 4'h0;
      a_wdata_reg <= {DW{1'b0}};
      ss_mode_reg <= `SS_WE_STROBE;
      async_done  <= 1'b0;
      async_rdata <= {DW{1'b0}};
    end else begin
      async_done <= 1'b0;
      if (ast_reg == A_IDLE)
        ss_mode_reg <= strobe_mode_select;
      case (ast_reg)
        A_IDLE: begin
          if (async_req && async_req_ready) begin
            a_wr_reg    <= async_write;
            a_addr_reg  <= async_addr;
            a_be_reg    <= async_be;
            a_wdata_reg <= async_wdata;
            acnt_reg    <= a_setup;
            ast_reg     <= A_SETUP;
          end
        end
        A_SETUP: begin
          acnt_reg <= acnt_reg - 4'h1;
          if (acnt_reg == 4'h0) begin
            acnt_reg <= a_strobe;
            ast_reg  <= A_STROBE;
          end
        end
        A_STROBE: begin
          if (strobe_end) begin
            if (!a_wr_reg)
              async_rdata <= mem_data_in;
            acnt_reg <= a_hold;
            ast_reg  <= A_HOLD;
          end else if (!(ext_wait_enable && wait_reg_sync)) begin
            acnt_reg <= acnt_reg - 4'h1;
          end
        end
        A_HOLD: begin
          acnt_reg <= acnt_reg - 4'h1;
          if (acnt_reg == 4'h0) begin
            async_done <= 1'b1;
            ast_reg    <= A_IDLE;
          end
        end
        default: ast_reg <= A_IDLE;
      endcase
    end
  end

  // pin drivers, async port owns the pins while it is active
  wire a_act = (ast_reg != A_IDLE);
  wire a_stb = (ast_reg == A_STROBE);

  always @(posedge clock) begin
    if (reset) begin
      sd_cs_n               <= 1'b1;
      {sd_ras_n, sd_cas_n, sd_we_n} <= `CMD_NOP;
      mem_addr_pins         <= 13'h0000;
      mem_bank_addr_pins    <= 2'h0;
      byte_mask_strobe_pins <= `NO_MASK;
      mem_data_out          <= {DW{1'b0}};
      mem_data_oe_n         <= 1'b1;
      async_chip_select_n   <= 1'b1;
      async_oe_n            <= 1'b1;
      async_we_n            <= 1'b1;
    end else if (a_act) begin
      sd_cs_n               <= 1'b1;
      {sd_ras_n, sd_cas_n, sd_we_n} <= `CMD_NOP;
      mem_addr_pins         <= a_addr_reg[14:2];
      mem_bank_addr_pins    <= a_addr_reg[1:0];
      mem_data_out          <= a_wdata_reg;
      mem_data_oe_n         <= !a_wr_reg;
      async_oe_n            <= !(a_stb && !a_wr_reg);
      async_we_n            <= !(a_stb && a_wr_reg && ss_mode_reg);
      if (ss_mode_reg == `SS_WE_STROBE) begin
        async_chip_select_n   <= 1'b0;
        byte_mask_strobe_pins <= (a_stb && a_wr_reg) ? ~a_be_reg
                                                     : `ALL_MASKED;
      end else begin
        async_chip_select_n   <= !a_stb;
        byte_mask_strobe_pins <= ~a_be_reg;
      end
    end else begin
      sd_cs_n               <= (st_reg == S_IDLE);
      {sd_ras_n, sd_cas_n, sd_we_n} <= cmd;
      mem_addr_pins         <= a_pins;
      mem_bank_addr_pins    <= m_bank;
      byte_mask_strobe_pins <= dqm;
      mem_data_out          <= wd_data;
      mem_data_oe_n         <= !take;
      async_chip_select_n   <= 1'b1;
      async_oe_n            <= 1'b1;
      async_we_n            <= 1'b1;
    end
  end
endmodule // sdram_write_map_async_modes

`default_nettype wire

// >>> verification/sdram_write_map_asserts.sv
/* Pin-level checker for the SDRAM write engine and the async strobe modes.
   Assumes it is bound onto sdram_write_map_async_modes and sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
`include "sdram_write_map_consts.vh"
module sdram_write_map_asserts (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       narrow_bus_select,
  input wire logic [3:0] t_rcd,
  input wire logic       wr_done,
  input wire logic       strobe_mode_select,
  input wire logic       async_done,
  input wire logic       sd_cs_n,
  input wire logic       sd_ras_n,
  input wire logic       sd_cas_n,
  input wire logic       sd_we_n,
  input wire logic [12:0] mem_addr_pins,
  input wire logic [1:0] mem_bank_addr_pins,
  input wire logic [3:0] byte_mask_strobe_pins,
  input wire logic       mem_data_oe_n,
  input wire logic       async_chip_select_n,
  input wire logic       async_oe_n,
  input wire logic       async_we_n
);
  wire [2:0] cmd = sd_cs_n ? `CMD_NOP : {sd_ras_n, sd_cas_n, sd_we_n};
  logic [4:0] act_age_reg;
  logic [1:0] act_bank_reg;
  // cycles since the last activate, saturating
  always @(posedge clock) begin
    if (reset) begin
      act_age_reg <= 5'h1F;
      act_bank_reg <= 2'h0;
    end else if (cmd == `CMD_ACT) begin
      act_age_reg <= 5'h01;
      act_bank_reg <= mem_bank_addr_pins;
    end else if (act_age_reg != 5'h1F) begin
      act_age_reg <= act_age_reg + 5'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_wrt_no_ap; cmd == `CMD_WRT |-> !mem_addr_pins[`AP_BIT]; endproperty
  a_wrt_no_ap: assert property (p_wrt_no_ap) else $error("write with precharge bit");
  property p_wrt_data; cmd == `CMD_WRT |-> !mem_data_oe_n; endproperty
  a_wrt_data: assert property (p_wrt_data) else $error("write without data drive");
  property p_rcd;
    cmd == `CMD_WRT && mem_bank_addr_pins == act_bank_reg |-> act_age_reg >= {1'b0, t_rcd};
  endproperty
  a_rcd: assert property (p_rcd) else $error("write too soon after activate");
  property p_mask_off; cmd inside {`CMD_ACT, `CMD_PRE, `CMD_BT} |-> byte_mask_strobe_pins == 4'h0;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masks on non-write command");
  property p_narrow_mask; narrow_bus_select && cmd == `CMD_WRT |-> byte_mask_strobe_pins[3:2] == 2'h3;
  endproperty
  a_narrow_mask: assert property (p_narrow_mask) else $error("upper lanes open on 16-bit");
  property p_done_quiet; wr_done |-> cmd == `CMD_NOP ##1 !wr_done; endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("done not a quiet pulse");
  property p_we_select;
    !strobe_mode_select && $fell(async_chip_select_n) |->
      async_oe_n && async_we_n ##1 !async_chip_select_n [*2];
  endproperty
  a_we_select: assert property (p_we_select) else $error("select not held in setup");
  property p_ss_select; strobe_mode_select && !async_chip_select_n |-> !(async_oe_n && async_we_n);
  endproperty
  a_ss_select: assert property (p_ss_select) else $error("select outside strobe");
  property p_async_end;
    async_done |-> async_oe_n && async_we_n ##1 async_chip_select_n; endproperty
  a_async_end: assert property (p_async_end) else $error("done while access live");
  c_write: cover property (cmd == `CMD_WRT);
  c_pre: cover property (cmd == `CMD_PRE);
  c_stop: cover property (cmd == `CMD_BT);
  c_ss_done: cover property (async_done && strobe_mode_select);
endmodule // sdram_write_map_asserts
`default_nettype wire

// >>> verification/sdram_async_partner.sv
/* Behavioural SDRAM bank/burst model plus async device with wait pin.
   Assumes the controller pins of sdram_write_map_async_modes, 8 column bits. */
`timescale 1ns/10ps
`default_nettype none
`include "sdram_write_map_consts.vh"
module sdram_async_partner #(
  parameter [31:0] RD_WORD = 32'h0
) (
  input wire logic        clock,
  input wire logic        link_clock,
  input wire logic        narrow_bus_select,
  input wire logic        sd_cs_n,
  input wire logic        sd_ras_n,
  input wire logic        sd_cas_n,
  input wire logic        sd_we_n,
  input wire logic [12:0] mem_addr_pins,
  input wire logic [1:0]  mem_bank_addr_pins,
  input wire logic [3:0]  byte_mask_strobe_pins,
  input wire logic [31:0] mem_data_out,
  input wire logic        mem_data_oe_n,
  input wire logic        async_chip_select_n,
  input wire logic        async_oe_n,
  input wire logic        wait_on,
  output logic [31:0]     mem_data_in,
  output logic            async_wait,
  output logic [7:0]      err_count
);
  logic [31:0] mem [0:1023];
  logic [3:0] open_bank = 4'h0;
  logic [1:0] bk;
  logic [7:0] col;
  logic [3:0] left = 4'h0;
  logic [3:0] off;
  logic [1:0] wcnt = 2'h0;
  wire [2:0] cmd = sd_cs_n ? `CMD_NOP : {sd_ras_n, sd_cas_n, sd_we_n};
  wire [3:0] bl = narrow_bus_select ? `BL_NARROW : `BL_WIDE;
  wire [7:0] bm = {4'h0, bl - 4'h1};
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 32'h0;
    err_count = 8'h0;
    mem_data_in = 32'h0;
    async_wait = 1'b0;
  end
  task put(input [1:0] b, input [7:0] c);
    for (int k = 0; k < 4; k++)
      if (!byte_mask_strobe_pins[k] && (k < 2 || !narrow_bus_select))
        mem[{b, c}][8*k +: 8] <= mem_data_out[8*k +: 8];
    if (byte_mask_strobe_pins != 4'hF && mem_data_oe_n) err_count <= err_count + 8'h1;
  endtask
  always @(posedge clock) begin
    case (cmd)
      `CMD_ACT: begin
        if (open_bank[mem_bank_addr_pins]) err_count <= err_count + 8'h1;
        open_bank[mem_bank_addr_pins] <= 1'b1;
        left <= 4'h0;
      end
      `CMD_PRE: begin
        open_bank[mem_bank_addr_pins] <= 1'b0;
        left <= 4'h0;
      end
      `CMD_BT: left <= 4'h0;
      `CMD_WRT: begin
        if (!open_bank[mem_bank_addr_pins]) err_count <= err_count + 8'h1;
        bk <= mem_bank_addr_pins;
        col <= mem_addr_pins[7:0];
        off <= 4'h1;
        left <= bl - 4'h1;
        put(mem_bank_addr_pins, mem_addr_pins[7:0]);
      end
      default: if (left != 4'h0) begin
        // burst wraps inside its aligned block
        put(bk, (col & ~bm) | ((col + {4'h0, off}) & bm));
        off <= off + 4'h1;
        left <= left - 4'h1;
      end
    endcase
    mem_data_in <= async_oe_n ? ~mem_data_in : RD_WORD;
  end
  // wait held for two link periods per access, pin pulled low otherwise
  always @(posedge link_clock) begin
    if (async_chip_select_n) begin
      async_wait <= 1'b0;
      wcnt <= 2'h0;
    end else if (wait_on && wcnt < 2'h2) begin
      async_wait <= 1'b1;
      wcnt <= wcnt + 2'h1;
    end else async_wait <= 1'b0;
  end
endmodule // sdram_async_partner
`default_nettype wire

// >>> verification/sdram_write_map_async_modes_tb.sv
/* Self-checking bench: SDRAM writes, address map, async strobe modes, ECC.
   Assumes the partner model and the checker files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module sdram_write_map_async_modes_tb;
  localparam [31:0] RD_WORD = 32'h5A3C96E1;
  logic clock = 1'b0, reset = 1'b1, link_clock = 1'b0;
  logic narrow_bus_select, wr_req, wd_valid, strobe_mode_select, nand_mode, wait_on;
  logic ext_wait_enable, async_req, async_write, ecc_clear;
  logic [1:0] bank_count_field, page_size_field;
  logic [3:0] t_rcd, t_rp, t_wr, wd_be, a_setup, a_strobe, a_hold, async_be;
  logic [31:0] wr_addr, wd_data, async_addr, async_wdata;
  logic [7:0] wr_len;
  logic [15:0] pat_hi;
  int bad_count, tests_run;
  wire wr_req_ready, wr_done, wd_ready, async_req_ready, async_done, async_wait;
  wire sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, mem_data_oe_n;
  wire async_chip_select_n, async_oe_n, async_we_n;
  wire [31:0] async_rdata, mem_data_out, mem_data_in;
  wire [23:0] ecc_value;
  wire [12:0] mem_addr_pins;
  wire [1:0] mem_bank_addr_pins;
  wire [3:0] byte_mask_strobe_pins;
  wire [7:0] err_count;
  always #5 clock = ~clock;
  initial begin
    #3;
    forever #40 link_clock = ~link_clock;
  end
  sdram_write_map_async_modes u_sdram_write_map_async_modes (.*);
  sdram_async_partner #(.RD_WORD(RD_WORD)) u_sdram_async_partner (.*);
  function [31:0] pat(input [7:0] i);
    pat = {pat_hi, ~i, i};
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task note(input string s);
    $display("test %s finished, mismatches %0d", s, bad_count);
  endtask
  task do_wr(input [31:0] a, input [7:0] n, input [3:0] be, input [7:0] stall_at);
    int i, k, st;
    logic tk, ac;
    logic [31:0] ex, w;
    logic [9:0] ix;
    logic [1:0] off;
    i = 0; k = 0; st = 0;
    @(negedge clock);
    wr_req = 1; wr_addr = a; wr_len = n; wd_be = be; wd_valid = 1; wd_data = pat(0);
    while (wr_done !== 1'b1 && k < 600) begin
      @(posedge clock);
      tk = wr_req && wr_req_ready;
      ac = wd_valid && wd_ready;
      @(negedge clock);
      k++;
      if (tk) wr_req = 0;
      if (ac) begin
        i++;
        wd_data = pat(i[7:0]);
        if (i == stall_at) st = 4;
      end
      if (st > 0) st--;
      wd_valid = (i < n) && (st == 0);
    end
    if (k >= 600) begin bad_count++; end_sim; end
    w = narrow_bus_select ? a >> 1 : a >> 2;
    off = narrow_bus_select ? {1'b0, a[0]} : a[1:0];
    for (i = 0; i < n; i++) begin
      ex = pat(i[7:0]);
      for (k = 0; k < 4; k++)
        if (!be[k] || (i == 0 && k < off) || (narrow_bus_select && k > 1)) ex[8*k +: 8] = 8'h0;
      ix = w[9:0] + i[9:0];
      `CHK(u_sdram_async_partner.mem[ix], ex)
    end
  endtask
  task do_async(input wr, input ss, input wt, input [3:0] be);
    int k;
    logic tk, seen;
    logic [7:0] cnt, ex;
    @(negedge clock);
    strobe_mode_select = ss; wait_on = wt;
    repeat (2) @(negedge clock);
    async_req = 1; async_write = wr; async_be = be; async_wdata = {pat_hi, 16'h0001};
    cnt = 0; seen = 0; k = 0;
    ex = ss ? a_strobe + 8'd1 : a_setup + a_strobe + a_hold + 8'd3;
    while (async_done !== 1'b1 && k < 300) begin
      @(posedge clock);
      tk = async_req && async_req_ready;
      @(negedge clock);
      k++;
      if (tk) async_req = 0;
      if (async_chip_select_n === 1'b0) cnt++;
      if (async_chip_select_n === 1'b0 && byte_mask_strobe_pins === ~be) seen = 1;
    end
    if (k >= 300) begin bad_count++; end_sim; end
    if (wt) `CHK(cnt > ex, 1'b1)
    else `CHK(cnt, ex)
    if (wr || ss) `CHK(seen, 1'b1)
    if (!wr) `CHK(async_rdata, RD_WORD)
    wait_on = 0;
  endtask
  task t_reset;
    `CHK({sd_cs_n, async_chip_select_n, mem_data_oe_n}, 3'h7)
    `CHK(byte_mask_strobe_pins, 4'h0)
    `CHK(wr_req_ready, 1'b1)
    note("reset");
  endtask
  task t_wide;
    pat_hi = 16'h1000;
    do_wr(32'h00000000, 8'd6, 4'hF, 8'd0);
    pat_hi = 16'h2000;
    do_wr(32'h00000106, 8'd3, 4'h9, 8'd0);
    note("wide");
  endtask
  task t_cross;
    pat_hi = 16'h3000;
    do_wr(32'h000003F8, 8'd4, 4'hF, 8'd2);
    note("cross");
  endtask
  task t_row;
    t_rcd = 4'h4;
    pat_hi = 16'h4000;
    do_wr(32'h00002020, 8'd2, 4'hF, 8'd0);
    pat_hi = 16'h4100;
    do_wr(32'h00000024, 8'd2, 4'hF, 8'd0);
    t_rcd = 4'h2;
    note("row");
  endtask
  task t_narrow;
    narrow_bus_select = 1;
    pat_hi = 16'h5000;
    do_wr(32'h00000301, 8'd9, 4'hF, 8'd0);
    narrow_bus_select = 0;
    note("narrow");
  endtask
  task t_modes;
    pat_hi = 16'h6000;
    do_async(1, 0, 0, 4'h5);
    do_async(0, 0, 0, 4'hF);
    a_strobe = 4'h4; a_hold = 4'h3;
    do_async(1, 1, 0, 4'h3);
    do_async(0, 1, 0, 4'hF);
    ext_wait_enable = 1; a_strobe = 4'hF;
    do_async(0, 0, 1, 4'hF);
    ext_wait_enable = 0; a_strobe = 4'h2;
    note("modes");
  endtask
  task t_ecc;
    @(negedge clock) ecc_clear = 1;
    @(negedge clock) ecc_clear = 0;
    nand_mode = 1;
    do_async(1, 0, 0, 4'hF);
    `CHK(ecc_value[17:0], 18'h15555)
    nand_mode = 0;
    @(negedge clock) ecc_clear = 1;
    @(negedge clock) ecc_clear = 0;
    @(negedge clock);
    `CHK(ecc_value, 24'h0)
    note("ecc");
  endtask
  initial begin
    bank_count_field = 2'h2; page_size_field = 2'h0; t_rcd = 4'h2; t_rp = 4'h2; t_wr = 4'h2;
    narrow_bus_select = 0; wr_req = 0; wr_addr = 0; wr_len = 0; wd_valid = 0; wd_data = 0;
    wd_be = 4'hF; strobe_mode_select = 0; nand_mode = 0; ext_wait_enable = 0; wait_on = 0;
    a_setup = 4'h1; a_strobe = 4'h2; a_hold = 4'h1; async_req = 0; async_write = 0;
    async_addr = 32'h00000040; async_be = 0; async_wdata = 0; ecc_clear = 0; pat_hi = 0;
    bad_count = 0; tests_run = 0;
    repeat (6) @(negedge clock);
    reset = 0;
    t_reset;
    t_wide;
    t_cross;
    t_row;
    t_narrow;
    t_modes;
    t_ecc;
    `CHK(err_count, 8'h00)
    end_sim;
  end
endmodule // sdram_write_map_async_modes_tb
bind sdram_write_map_async_modes sdram_write_map_asserts u_sdram_write_map_asserts (.*);
`default_nettype wire
